/* File: cond_block_defs.svh */
// Constants for the conditional group and table branch decoder
`ifndef COND_BLOCK_DEFS_SVH
`define COND_BLOCK_DEFS_SVH
`define COND_AL          4'hE
`define GROUP_MAX_SLOTS  3'h4
`define MASK_EMPTY       4'h0
`define FLAGS_RESET      4'h0
`define TBL_READ_CYCLES_NS 10
`define TBL_READ_CYCLES  ((`TBL_READ_CYCLES_NS + 9) / 10)
`endif

/* File: cond_block_pkg.sv */
// Types for the conditional group and table branch decoder
package cond_block_pkg;
  typedef enum logic [2:0] {
    KIND_OTHER  = 3'h0,
    KIND_PREFIX = 3'h1,
    KIND_TBB    = 3'h2,
    KIND_TBH    = 3'h3,
    KIND_BREAKPOINT_INSTR   = 3'h4,
    KIND_FLOAT  = 3'h5,
    KIND_FCMP   = 3'h6
  } instr_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } tb_state_t;
endpackage : cond_block_pkg

/* File: cond_eval.sv */
// Condition code evaluation against the N Z C V flags
`timescale 1ns/1ns
module cond_eval (
  input  wire logic [3:0] cond,
  input  wire logic [3:0] flags,
  output logic            pass
);
  logic n, z, c, v;
  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];
  // Even codes test, odd codes invert, except code F
  always_comb begin
    logic base;
    base = 1'b1;
    case (cond[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = ~z & (n == v);
      default: base = 1'b1;
    endcase
    pass = (cond[0] && cond != 4'hF) ? ~base : base;
  end
endmodule : cond_eval

/* File: cond_block_decoder.sv */
// Conditional group tracking, table branch sequencing and float gate
`timescale 1ns/1ns
`include "cond_block_defs.svh"
// Notes on behaviour
// - Conditionals other than the conditional branch live in groups; it reaches further inside.
// - The group prefix leaves the condition flags untouched.
// - A program counter base makes the table start right after the table branch.
// - The halfword table branch doubles the index to form the entry offset.
// - The branch distance is twice the unsigned entry, so it is always forward.
// - The target is the address after the table branch plus that distance.
// - Float instructions are accepted only with the float unit present and enabled; a passing float flag writer still updates the flags without it.
// - The signalling float compare adds an invalid operation check.
// - The prefix conditions one to four instructions, each then or else per the mask.
// - A breakpoint inside a group always executes.
// - Group state is saved and restored across exceptions so the group resumes.
module cond_block_decoder
  import cond_block_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire instr_kind_t instr_kind,
  input  wire logic [3:0]  instr_cond,
  input  wire logic [7:0]  prefix_field,
  input  wire logic        pc_write,
  input  wire logic [31:0] instr_addr,
  input  wire logic [1:0]  instr_len,
  input  wire logic        base_is_pc,
  input  wire logic [31:0] base_value,
  input  wire logic [31:0] index_value,
  input  wire logic [3:0]  flags_in,
  input  wire logic        flags_wr,
  input  wire logic        fpu_present,
  input  wire logic        fpu_enable,
  input  wire logic        exc_entry,
  input  wire logic        exc_return,
  input  wire logic [7:0]  exc_restore,
  input  wire logic        mem_rdy,
  input  wire logic [15:0] mem_rdata,
  output logic             instr_exec,
  output logic             instr_busy,
  output logic             in_group,
  output logic [7:0]       group_state,
  output logic [3:0]       flags_out,
  output logic             fpu_fault,
  output logic             fcmp_invalid_chk,
  output logic             mem_req,
  output logic             mem_half,
  output logic [31:0]      mem_addr,
  output logic             branch_valid,
  output logic [31:0]      branch_target
);
  // Group state: base condition high nibble, slot mask low nibble
  logic [7:0]  state_reg;
  logic [7:0]  state_next;
  logic [3:0]  flags_reg;
  tb_state_t   tb_reg;
  logic [31:0] next_addr_reg;
  logic [3:0]  cur_cond;
  logic        cur_pass;
  logic        tb_start;
  logic        accept;
  logic        fpu_ok;

  // Slot condition: base with low bit from mask top
  function automatic logic [3:0] slot_cond(input logic [7:0] st);
    slot_cond = {st[7:5], st[4]};
  endfunction : slot_cond

  function automatic logic group_active(input logic [7:0] st);
    group_active = (st[3:0] != `MASK_EMPTY);
  endfunction : group_active

  assign cur_cond = group_active(state_reg) ? slot_cond(state_reg) : instr_cond;

  cond_eval u_eval (
    .cond  (cur_cond),
    .flags (flags_reg),
    .pass  (cur_pass)
  );

  assign fpu_ok   = fpu_present & fpu_enable;
  assign accept   = instr_valid & (tb_reg == ST_IDLE);
  assign tb_start = accept & cur_pass &
                    (instr_kind == KIND_TBB || instr_kind == KIND_TBH);

  // Advance the mask by one slot; empty after the last
  always_comb begin
    state_next = state_reg;
    if (accept && group_active(state_reg)) begin
      if (state_reg[2:0] == 3'h0) begin
        state_next = 8'h00;
      end else begin
        state_next = {state_reg[7:5], state_reg[4:0] << 1};
      end
    end else if (accept && instr_kind == KIND_PREFIX) begin
      state_next = prefix_field;
    end
  end

  // Group state, saved externally on exception entry and restored on return
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= 8'h00;
    end else if (exc_return) begin
      state_reg <= exc_restore;
    end else if (exc_entry) begin
      state_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Flags change only by a passing writer; the prefix never writes
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= `FLAGS_RESET;
    end else if (accept && flags_wr && cur_pass && instr_kind != KIND_PREFIX) begin
      flags_reg <= flags_in;
    end
  end

  // Execute strobe; failed members become no-ops, breakpoints always run
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_exec       <= 1'b0;
      fpu_fault        <= 1'b0;
      fcmp_invalid_chk <= 1'b0;
    end else begin
      instr_exec <= accept && instr_kind != KIND_PREFIX &&
                    (cur_pass || instr_kind == KIND_BREAKPOINT_INSTR) &&
                    !((instr_kind == KIND_FLOAT || instr_kind == KIND_FCMP) && !fpu_ok);
      fpu_fault  <= accept && cur_pass && !fpu_ok &&
                    (instr_kind == KIND_FLOAT || instr_kind == KIND_FCMP);
      fcmp_invalid_chk <= accept && cur_pass && fpu_ok &&
                          instr_kind == KIND_FCMP;
    end
  end

  // Table branch sequencer: one memory read, then the branch
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_reg        <= ST_IDLE;
      mem_req       <= 1'b0;
      mem_half      <= 1'b0;
      mem_addr      <= 32'h0000_0000;
      next_addr_reg <= 32'h0000_0000;
    end else begin
      case (tb_reg)
        ST_IDLE: begin
          if (tb_start && !exc_entry) begin
            next_addr_reg <= instr_addr + {29'h0, instr_len, 1'b0};
            mem_half      <= (instr_kind == KIND_TBH);
            // Entry address: base plus index, doubled for halfword tables
            mem_addr <= (base_is_pc ? instr_addr + {29'h0, instr_len, 1'b0}
                                    : base_value) +
                        ((instr_kind == KIND_TBH) ? {index_value[30:0], 1'b0}
                                                  : index_value);
            mem_req  <= 1'b1;
            tb_reg   <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_rdy) begin
            mem_req <= 1'b0;
            tb_reg  <= ST_DONE;
          end
        end
        ST_DONE: begin
          tb_reg <= ST_IDLE;
        end
        default: begin
          tb_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Branch output; distance is twice the unsigned entry
  always_ff @(posedge clk) begin
    if (rst) begin
      branch_valid  <= 1'b0;
      branch_target <= 32'h0000_0000;
    end else if (tb_reg == ST_FETCH && mem_rdy) begin
      branch_valid  <= 1'b1;
      branch_target <= next_addr_reg +
                       (mem_half ? {15'h0000, mem_rdata, 1'b0}
                                 : {23'h00_0000, mem_rdata[7:0], 1'b0});
    end else begin
      branch_valid  <= 1'b0;
    end
  end

  // Registered status views; same priority as the group state so the views never lag it
  always_ff @(posedge clk) begin
    if (rst) begin
      in_group    <= 1'b0;
      group_state <= 8'h00;
      instr_busy  <= 1'b0;
    end else begin
      if (exc_return) begin
        in_group    <= group_active(exc_restore);
        group_state <= exc_restore;
      end else if (exc_entry) begin
        in_group    <= 1'b0;
        group_state <= 8'h00;
      end else begin
        in_group    <= group_active(state_next);
        group_state <= state_next;
      end
      instr_busy  <= (tb_reg == ST_IDLE) ? (tb_start && !exc_entry) : (tb_reg == ST_FETCH);
    end
  end
  assign flags_out = flags_reg;

  a_prefix_flags: assert property (@(posedge clk) disable iff (rst)
    (accept && instr_kind == KIND_PREFIX) |=> flags_reg == $past(flags_reg))
    else $error("prefix changed flags");
  a_group_length: assert property (@(posedge clk) disable iff (rst)
    (accept && instr_kind == KIND_PREFIX && !group_active(state_reg) && !exc_entry
     && !exc_return && prefix_field[3:0] == 4'h8) |=> group_active(state_reg))
    else $error("group not opened");
  a_breakpoint_instr_runs: assert property (@(posedge clk) disable iff (rst)
    (accept && instr_kind == KIND_BREAKPOINT_INSTR) |=> instr_exec)
    else $error("breakpoint skipped");
  a_fpu_gate: assert property (@(posedge clk) disable iff (rst)
    (accept && !fpu_ok && instr_kind == KIND_FLOAT) |=> !instr_exec)
    else $error("float ran without unit");
  a_fcmp_check: assert property (@(posedge clk) disable iff (rst)
    (accept && cur_pass && fpu_ok && instr_kind == KIND_FCMP) |=> fcmp_invalid_chk)
    else $error("no invalid check");
  a_exc_restore: assert property (@(posedge clk) disable iff (rst)
    exc_return |=> state_reg == $past(exc_restore))
    else $error("group not restored");
  a_fail_noop: assert property (@(posedge clk) disable iff (rst)
    (accept && !cur_pass && instr_kind == KIND_OTHER) |=>
    !instr_exec && flags_reg == $past(flags_reg))
    else $error("failed member had effect");
  a_tb_forward: assert property (@(posedge clk) disable iff (rst)
    branch_valid |-> branch_target >= next_addr_reg)
    else $error("table branch went backward");
  a_tb_latency: assert property (@(posedge clk) disable iff (rst)
    (tb_reg == ST_FETCH && mem_rdy) |=> branch_valid ##1 (tb_reg == ST_IDLE))
    else $error("branch timing");
  a_tbh_addr: assert property (@(posedge clk) disable iff (rst)
    (tb_start && !exc_entry && instr_kind == KIND_TBH && base_is_pc) |=>
    mem_addr == $past(instr_addr) + {29'h0, $past(instr_len), 1'b0} +
                {$past(index_value[30:0]), 1'b0})
    else $error("halfword entry address");
endmodule : cond_block_decoder

/* File: table_mem_model.sv */
// Table memory model answering the decoder's table reads
`timescale 1ns/1ns
module table_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [3:0]  delay,
  input  wire logic [15:0] word,
  output logic             mem_rdy,
  output logic [15:0]      mem_rdata
);
  logic [3:0] wait_cnt;

  initial begin
    mem_rdy = 1'b0;
    mem_rdata = 16'h0000;
    wait_cnt = 4'h0;
  end

  // Answer after the set delay; idle data toggles so stale data never matches
  always @(negedge clk) begin
    if (mem_req && !mem_rdy && wait_cnt == delay) begin
      mem_rdy   <= 1'b1;
      mem_rdata <= word;
      wait_cnt  <= 4'h0;
    end else begin
      mem_rdy   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= mem_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : table_mem_model

/* File: test_cond_block_and_table_branch.sv */
// Self-checking bench for the conditional group and table branch decoder
`timescale 1ns/1ns
module test_cond_block_and_table_branch;
  import cond_block_pkg::*;
  instr_kind_t instr_kind;
  logic [3:0]  instr_cond, flags_in, flags_out, dly;
  logic [7:0]  prefix_field, exc_restore, group_state, gs;
  logic [31:0] instr_addr, base_value, index_value, mem_addr, branch_target;
  logic [1:0]  instr_len;
  logic [15:0] mem_rdata, word;
  logic clk, rst, instr_valid, pc_write, base_is_pc, flags_wr, fpu_present, fpu_enable;
  logic exc_entry, exc_return, mem_rdy, instr_exec, instr_busy, in_group, fpu_fault;
  logic fcmp_invalid_chk, mem_req, mem_half, branch_valid;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cycles = 0;

  cond_block_decoder uut (.clk, .rst, .instr_valid, .instr_kind, .instr_cond, .prefix_field,
    .pc_write, .instr_addr, .instr_len, .base_is_pc, .base_value, .index_value, .flags_in,
    .flags_wr, .fpu_present, .fpu_enable, .exc_entry, .exc_return, .exc_restore, .mem_rdy,
    .mem_rdata, .instr_exec, .instr_busy, .in_group, .group_state, .flags_out, .fpu_fault,
    .fcmp_invalid_chk, .mem_req, .mem_half, .mem_addr, .branch_valid, .branch_target);
  table_mem_model mem (.clk, .mem_req, .delay(dly), .word, .mem_rdy, .mem_rdata);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One instruction for one cycle; outputs are settled on return
  task automatic issue(input instr_kind_t k, input logic [7:0] f, input logic fw);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_kind = k;
    prefix_field = f;
    flags_wr = fw;
    @(negedge clk);
    instr_valid = 1'b0;
    flags_wr = 1'b0;
  endtask : issue

  // Table branch; program side never uses stack pointer as base or index
  task automatic table_br(input instr_kind_t k, input logic pc, input logic [31:0] a, b, i,
                          input logic [31:0] ea, et, input logic [3:0] d, input logic [15:0] w);
    instr_addr = a;
    base_is_pc = pc;
    base_value = b;
    index_value = i;
    dly = d;
    word = w;
    issue(k, 8'h00, 1'b0);
    check("table busy", instr_busy, 1'b1);
    check("table req", mem_req, 1'b1);
    check("table addr", mem_addr, ea);
    check("table half", mem_half, k == KIND_TBH);
    repeat (20) if (branch_valid !== 1'b1) @(negedge clk);
    check("branch valid", branch_valid, 1'b1);
    check("branch target", branch_target, et);
    repeat (3) @(negedge clk);
    check("table idle", instr_busy, 1'b0);
    check("table req done", mem_req, 1'b0);
  endtask : table_br

  task automatic t_flags;
    flags_in = 4'h4;
    issue(KIND_OTHER, 8'h00, 1'b1);
    flags_in = 4'h0;
    issue(KIND_PREFIX, 8'h08, 1'b1);
    check("flags after prefix", flags_out, 4'h4);
    check("group open", in_group, 1'b1);
    issue(KIND_OTHER, 8'h00, 1'b0);
    check("member exec", instr_exec, 1'b1);
    check("group closed", in_group, 1'b0);
    // Outside a group the own condition decides; NE fails with Z set
    instr_cond = 4'h1;
    issue(KIND_OTHER, 8'h00, 1'b0);
    check("own cond fail", instr_exec, 1'b0);
    instr_cond = 4'hE;
  endtask : t_flags

  // Base NE with else slot; members carry base or inverse only
  task automatic t_slots;
    issue(KIND_PREFIX, 8'h14, 1'b0);
    issue(KIND_OTHER, 8'h00, 1'b1);
    check("failed member", instr_exec, 1'b0);
    check("failed flags", flags_out, 4'h4);
    check("still in group", in_group, 1'b1);
    issue(KIND_OTHER, 8'h00, 1'b0);
    check("else member", instr_exec, 1'b1);
    check("two slot end", in_group, 1'b0);
    issue(KIND_PREFIX, 8'h18, 1'b0);
    issue(KIND_BREAKPOINT_INSTR, 8'h00, 1'b0);
    check("breakpoint exec", instr_exec, 1'b1);
  endtask : t_slots

  task automatic t_exc;
    issue(KIND_PREFIX, 8'h04, 1'b0);
    gs = group_state;
    @(negedge clk);
    exc_entry = 1'b1;
    @(negedge clk);
    exc_entry = 1'b0;
    check("group cleared", in_group, 1'b0);
    exc_restore = gs;
    exc_return = 1'b1;
    @(negedge clk);
    exc_return = 1'b0;
    check("group restored", group_state, gs);
    repeat (2) issue(KIND_OTHER, 8'h00, 1'b0);
    check("resumed end", in_group, 1'b0);
  endtask : t_exc

  task automatic t_float;
    for (int n = 0; n < 4; n++) begin
      fpu_present = n[1];
      fpu_enable = n[0];
      issue(KIND_FLOAT, 8'h00, 1'b0);
      check("float fault", fpu_fault, n != 3);
      check("float exec", instr_exec, n == 3);
    end
    check("plain no check", fcmp_invalid_chk, 1'b0);
    issue(KIND_FCMP, 8'h00, 1'b0);
    check("signalling check", fcmp_invalid_chk, 1'b1);
  endtask : t_float

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, instr_valid, pc_write, base_is_pc, flags_wr, exc_entry, exc_return} = 7'h40;
    {fpu_present, fpu_enable, prefix_field, exc_restore} = 18'h0;
    instr_kind = KIND_OTHER;
    {instr_addr, base_value, index_value, word, dly, flags_in} = 124'h0;
    instr_cond = 4'hE;
    instr_len = 2'h2;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_flags();
    t_slots();
    table_br(KIND_TBH, 1'b1, 32'h1000, 32'h0, 32'h3, 32'h100A, 32'h11006, 4'h3, 16'h8001);
    table_br(KIND_TBB, 1'b0, 32'h3000, 32'h2000, 32'h5, 32'h2005, 32'h3202, 4'h0, 16'hA5FF);
    t_exc();
    t_float();
    tally_and_finish();
  end
endmodule : test_cond_block_and_table_branch
